/* File: pkg/awc_pkg.sv */
// Shared constants and carrier types of the add-with-carry execution block
`default_nettype none
package awc_pkg;

   // ===========================================================
   // Instruction fields
   localparam logic [4:0] OPC_AWC = 5'h09;
   localparam int OPC_LSB = 19;
   localparam int BASE_LSB = 15;
   localparam int SIZE_BIT = 14;
   localparam int DMODE_LSB = 11;
   localparam int DREG_LSB = 7;
   localparam int LITSEL_LSB = 5;
   localparam logic [1:0] LITSEL = 2'h3;
   localparam int SMODE_LSB = 4;
   localparam int SREG_LSB = 0;
   localparam int IMM_LSB = 0;
   localparam int INSTR_W = 24;

   // ===========================================================
   // Status register flag positions
   localparam int F_C = 0;
   localparam int F_Z = 1;
   localparam int F_WRAP = 2;
   localparam int F_N = 3;
   localparam int F_NIB = 8;
   localparam logic [15:0] SR_RST = 16'h0000;

   // ===========================================================
   // APB map: byte offsets in the low address byte
   localparam int ADDR_W = 8;
   localparam logic [7:0] OFF_INSTR = 8'h00;
   localparam logic [7:0] OFF_STATUS = 8'h04;
   localparam logic [7:0] OFF_INFO = 8'h08;
   localparam logic [7:0] OFF_WREG = 8'h40;
   localparam logic [7:0] MASK_WREG = 8'hc3;
   localparam logic [7:0] OFF_DMEM = 8'h80;
   localparam logic [7:0] MASK_DMEM = 8'h83;
   localparam int IDX_LSB = 2;
   localparam int INFO_BAD_BIT = 8;

   // ===========================================================
   // Storage geometry and pointer steps
   localparam int NWREG = 16;
   localparam int NMEM = 32;
   localparam int MEM_LSB = 1;
   localparam int MEM_AW = 5;
   localparam logic [15:0] STEP_BYTE = 16'h0001;
   localparam logic [15:0] STEP_WORD = 16'h0002;

   typedef enum logic [2:0] {
      MODE_DIR = 3'h0,
      MODE_IND = 3'h1,
      MODE_POSTDEC = 3'h2,
      MODE_POSTINC = 3'h3,
      MODE_PREDEC = 3'h4,
      MODE_PREINC = 3'h5
   } awc_mode_e;

   typedef struct packed {
      logic lit_form;
      logic reg_form;
      logic [3:0] base;
      logic byte_op;
      awc_mode_e dmode;
      logic [3:0] dreg;
      awc_mode_e smode;
      logic [3:0] sreg;
      logic [4:0] imm;
   } awc_dec_s;

   typedef struct packed {
      logic nib;
      logic n;
      logic wrap;
      logic z;
      logic c;
   } awc_flags_s;

   typedef struct packed {
      logic [NWREG-1:0][15:0] wreg;
      logic [NMEM-1:0][15:0] dmem;
      logic [15:0] sr;
      logic [23:0] last_instr;
      logic [15:0] last_res;
      logic [7:0] exec_cnt;
      logic bad_op;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } awc_state_s;

endpackage
`default_nettype wire

/* File: rtl/awc_decode.sv */
// Instruction field decoder for the two add-with-carry forms
`timescale 1ns/10ps
`default_nettype none

module awc_decode (
   input wire logic [23:0] instr,
   output awc_pkg::awc_dec_s dec
);

   logic opc_hit;
   logic lit_sel;

   // ===========================================================
   // Field extraction
   always_comb begin
      opc_hit = (instr[awc_pkg::OPC_LSB +: 5] == awc_pkg::OPC_AWC);
      lit_sel = (instr[awc_pkg::LITSEL_LSB +: 2] == awc_pkg::LITSEL);
      dec.lit_form = opc_hit & lit_sel;
      // Source mode field overlaps the literal selector, so 11x means literal form
      dec.reg_form = opc_hit & ~lit_sel;
      dec.base = instr[awc_pkg::BASE_LSB +: 4];
      dec.byte_op = instr[awc_pkg::SIZE_BIT];
      dec.dmode = awc_pkg::awc_mode_e'(instr[awc_pkg::DMODE_LSB +: 3]);
      dec.dreg = instr[awc_pkg::DREG_LSB +: 4];
      dec.smode = awc_pkg::awc_mode_e'(instr[awc_pkg::SMODE_LSB +: 3]);
      dec.sreg = instr[awc_pkg::SREG_LSB +: 4];
      dec.imm = instr[awc_pkg::IMM_LSB +: 5];
   end

endmodule // awc_decode
`default_nettype wire

/* File: rtl/awc_adder.sv */
// Byte or word adder with carry in and status flag generation
`timescale 1ns/10ps
`default_nettype none

module awc_adder (
   input wire logic [15:0] opa,
   input wire logic [15:0] opb,
   input wire logic cin,
   input wire logic z_in,
   input wire logic byte_op,
   output logic [15:0] sum,
   output awc_pkg::awc_flags_s flags
);

   logic [4:0] nib;
   logic [8:0] lo9;
   logic [16:0] w17;

   // ===========================================================
   // Sum and flags
   always_comb begin
      nib = {1'b0, opa[3:0]} + {1'b0, opb[3:0]} + {4'h0, cin};
      lo9 = {1'b0, opa[7:0]} + {1'b0, opb[7:0]} + {8'h00, cin};
      w17 = {1'b0, opa} + {1'b0, opb} + {16'h0000, cin};
      if (byte_op) begin
         // Flags follow the 8-bit result only
         sum = {opa[15:8], lo9[7:0]};
         flags.c = lo9[8];
         flags.nib = nib[4];
         flags.n = lo9[7];
         flags.wrap = (opa[7] == opb[7]) && (lo9[7] != opa[7]);
         // Zero may only be cleared, never set
         flags.z = z_in & (lo9[7:0] == 8'h00);
      end else begin
         sum = w17[15:0];
         flags.c = w17[16];
         flags.nib = lo9[8];
         flags.n = w17[15];
         flags.wrap = (opa[15] == opb[15]) && (w17[15] != opa[15]);
         flags.z = z_in & (w17[15:0] == 16'h0000);
      end
   end

endmodule // awc_adder
`default_nettype wire

/* File: rtl/awc_exec.sv */
// Add-with-carry execution unit with APB access to working registers and data memory
`timescale 1ns/10ps
`default_nettype none

module awc_exec (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr
);

   awc_pkg::awc_state_s q;
   awc_pkg::awc_state_s d;
   awc_pkg::awc_dec_s dec;
   awc_pkg::awc_flags_s fl;
   logic [15:0] sum;
   logic [15:0] step;
   logic [15:0] base_val;
   logic [15:0] opb;
   logic [15:0] src_ea;
   logic [15:0] dst_ea;
   logic [15:0] sr_n;
   logic [15:0] dword;
   logic [7:0] low_addr;
   logic legal;
   logic acc;
   logic hit_instr;
   logic hit_status;
   logic hit_info;
   logic hit_wreg;
   logic hit_dmem;
   logic hit;
   logic [31:0] rd_val;

   // ===========================================================
   // Helpers
   function automatic logic [15:0] ea_of(
      input awc_pkg::awc_mode_e m,
      input logic [15:0] r,
      input logic [15:0] s
   );
      unique case (m)
         awc_pkg::MODE_PREDEC: ea_of = r - s;
         awc_pkg::MODE_PREINC: ea_of = r + s;
         default: ea_of = r;
      endcase
   endfunction

   function automatic logic [15:0] ptr_upd(
      input awc_pkg::awc_mode_e m,
      input logic [15:0] r,
      input logic [15:0] s
   );
      unique case (m)
         awc_pkg::MODE_POSTDEC,
         awc_pkg::MODE_PREDEC: ptr_upd = r - s;
         awc_pkg::MODE_POSTINC,
         awc_pkg::MODE_PREINC: ptr_upd = r + s;
         default: ptr_upd = r;
      endcase
   endfunction

   function automatic logic mode_ok(input awc_pkg::awc_mode_e m);
      unique case (m)
         awc_pkg::MODE_DIR,
         awc_pkg::MODE_IND,
         awc_pkg::MODE_POSTDEC,
         awc_pkg::MODE_POSTINC,
         awc_pkg::MODE_PREDEC,
         awc_pkg::MODE_PREINC: mode_ok = 1'b1;
         default: mode_ok = 1'b0;
      endcase
   endfunction

   // Memory read of a byte lane or a whole word; byte reads are zero-extended
   function automatic logic [15:0] mem_rd(
      input logic [15:0] w,
      input logic lane,
      input logic bop
   );
      if (!bop) begin
         mem_rd = w;
      end else if (lane) begin
         mem_rd = {8'h00, w[15:8]};
      end else begin
         mem_rd = {8'h00, w[7:0]};
      end
   endfunction

   // Applies the two low byte strobes to a 16-bit register
   function automatic logic [15:0] merge(
      input logic [15:0] old,
      input logic [31:0] wd,
      input logic [3:0] st
   );
      merge[7:0] = st[0] ? wd[7:0] : old[7:0];
      merge[15:8] = st[1] ? wd[15:8] : old[15:8];
   endfunction

   // ===========================================================
   // Decode and arithmetic
   awc_decode u_decode (
      .instr(pwdata[awc_pkg::INSTR_W-1:0]),
      .dec(dec)
   );

   awc_adder u_adder (
      .opa(base_val),
      .opb(opb),
      .cin(q.sr[awc_pkg::F_C]),
      .z_in(q.sr[awc_pkg::F_Z]),
      .byte_op(dec.byte_op),
      .sum(sum),
      .flags(fl)
   );

   // ===========================================================
   // Operand fetch
   always_comb begin
      step = dec.byte_op ? awc_pkg::STEP_BYTE : awc_pkg::STEP_WORD;
      base_val = q.wreg[dec.base];
      src_ea = ea_of(dec.smode, q.wreg[dec.sreg], step);
      dst_ea = ea_of(dec.dmode, q.wreg[dec.dreg], step);
      if (dec.lit_form) begin
         opb = {11'h000, dec.imm};
      end else if (dec.smode == awc_pkg::MODE_DIR) begin
         opb = q.wreg[dec.sreg];
      end else begin
         // Memory is small: upper address bits wrap onto the same words
         opb = mem_rd(q.dmem[src_ea[awc_pkg::MEM_LSB +: awc_pkg::MEM_AW]],
                      src_ea[0], dec.byte_op);
      end
      legal = (dec.lit_form | (dec.reg_form & mode_ok(dec.smode)))
            & mode_ok(dec.dmode);
      sr_n = q.sr;
      sr_n[awc_pkg::F_C] = fl.c;
      sr_n[awc_pkg::F_Z] = fl.z;
      sr_n[awc_pkg::F_WRAP] = fl.wrap;
      sr_n[awc_pkg::F_N] = fl.n;
      sr_n[awc_pkg::F_NIB] = fl.nib;
   end

   // ===========================================================
   // APB address decode and read data
   always_comb begin
      low_addr = paddr[awc_pkg::ADDR_W-1:0];
      hit_instr = (low_addr == awc_pkg::OFF_INSTR);
      hit_status = (low_addr == awc_pkg::OFF_STATUS);
      hit_info = (low_addr == awc_pkg::OFF_INFO);
      hit_wreg = ((low_addr & awc_pkg::MASK_WREG) == awc_pkg::OFF_WREG);
      hit_dmem = ((low_addr & awc_pkg::MASK_DMEM) == awc_pkg::OFF_DMEM);
      hit = (paddr[31:awc_pkg::ADDR_W] == '0)
          & (hit_instr | hit_status | hit_info | hit_wreg | hit_dmem);
      acc = psel & penable;
      rd_val = 32'h0000_0000;
      if (hit_instr) begin
         rd_val = {8'h00, q.last_instr};
      end else if (hit_status) begin
         rd_val = {16'h0000, q.sr};
      end else if (hit_info) begin
         rd_val = {q.last_res, 7'h00, q.bad_op, q.exec_cnt};
      end else if (hit_wreg) begin
         rd_val = {16'h0000, q.wreg[paddr[awc_pkg::IDX_LSB +: 4]]};
      end else if (hit_dmem) begin
         rd_val = {16'h0000, q.dmem[paddr[awc_pkg::IDX_LSB +: awc_pkg::MEM_AW]]};
      end
      if (!hit) begin
         rd_val = 32'h0000_0000;
      end
   end

   // ===========================================================
   // Next state
   always_comb begin
      d = q;
      d.pready = 1'b0;
      d.pslverr = 1'b0;
      dword = q.dmem[dst_ea[awc_pkg::MEM_LSB +: awc_pkg::MEM_AW]];
      // One wait state: the answer is registered in the first access cycle
      if (acc && !q.pready) begin
         d.pready = 1'b1;
         d.prdata = pwrite ? 32'h0000_0000 : rd_val;
         d.pslverr = ~hit;
      end
      // Writes take effect only at the edge that completes the transfer
      if (acc && q.pready && pwrite && hit) begin
         if (hit_instr) begin
            d.last_instr = pwdata[awc_pkg::INSTR_W-1:0];
            if (!legal) begin
               d.bad_op = 1'b1;
            end else begin
               // Whole instruction retires at this one edge
               d.exec_cnt = q.exec_cnt + 8'h01;
               d.last_res = sum;
               d.sr = sr_n;
               if (dec.reg_form) begin
                  d.wreg[dec.sreg] = ptr_upd(dec.smode, q.wreg[dec.sreg], step);
               end
               d.wreg[dec.dreg] = ptr_upd(dec.dmode, d.wreg[dec.dreg], step);
               if (dec.dmode == awc_pkg::MODE_DIR) begin
                  if (dec.byte_op) begin
                     d.wreg[dec.dreg][7:0] = sum[7:0];
                  end else begin
                     d.wreg[dec.dreg] = sum;
                  end
               end else begin
                  if (!dec.byte_op) begin
                     dword = sum;
                  end else if (dst_ea[0]) begin
                     dword[15:8] = sum[7:0];
                  end else begin
                     dword[7:0] = sum[7:0];
                  end
                  d.dmem[dst_ea[awc_pkg::MEM_LSB +: awc_pkg::MEM_AW]] = dword;
               end
            end
         end else if (hit_status) begin
            d.sr = merge(q.sr, pwdata, pstrb);
         end else if (hit_info) begin
            // Write one to clear the bad-instruction flag
            if (pstrb[1] && pwdata[awc_pkg::INFO_BAD_BIT]) begin
               d.bad_op = 1'b0;
            end
         end else if (hit_wreg) begin
            d.wreg[paddr[awc_pkg::IDX_LSB +: 4]] =
               merge(q.wreg[paddr[awc_pkg::IDX_LSB +: 4]], pwdata, pstrb);
         end else begin
            d.dmem[paddr[awc_pkg::IDX_LSB +: awc_pkg::MEM_AW]] =
               merge(q.dmem[paddr[awc_pkg::IDX_LSB +: awc_pkg::MEM_AW]], pwdata, pstrb);
         end
      end
   end

   // ===========================================================
   // State register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q <= '0;
         q.sr <= awc_pkg::SR_RST;
      end else begin
         q <= d;
      end
   end

   assign prdata = q.prdata;
   assign pready = q.pready;
   assign pslverr = q.pslverr;

endmodule // awc_exec
`default_nettype wire

/* File: verif/awc_assertions.sv */
// Concurrent checks on the APB port of the add-with-carry execution unit
`timescale 1ns/10ps
`default_nettype none
module awc_assertions (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);
   // =====
   // Map holes
   logic miss;
   assign miss = (paddr[31:8] != 24'h0) || (paddr[1:0] != 2'h0) ||
      (paddr[7:6] == 2'h0 && paddr[5:2] > 4'h2);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   // =====
   // Transfer steps
   sequence s_wait;
      psel && penable && !pready;
   endsequence
   sequence s_pulse;
      pready ##1 !pready;
   endsequence
   a_one_wait: assert property (s_wait |=> s_pulse)
      else $error("answer not after one wait state");
   a_ready_access: assert property (pready |-> psel && penable)
      else $error("ready outside an access");
   a_miss_err: assert property (s_wait ##0 miss |=> pslverr)
      else $error("unmapped address not refused");
   a_hit_ok: assert property (s_wait ##0 !miss |=> !pslverr)
      else $error("mapped address refused");
   a_err_clean: assert property (pslverr |-> pready && prdata == 32'h0)
      else $error("error without ready or with data");
   a_write_quiet: assert property (pready && pwrite |-> prdata == 32'h0)
      else $error("write answered with data");
   a_half_word: assert property (
      pready && !pwrite && (paddr[7:6] != 2'h0 || paddr[7:0] == 8'h04)
      |-> prdata[31:16] == 16'h0)
      else $error("upper half of a 16-bit register not zero");
   a_instr_word: assert property (
      pready && !pwrite && paddr == 32'h0 |-> prdata[31:24] == 8'h0)
      else $error("instruction wider than 24 bits");
endmodule // awc_assertions
`default_nettype wire

/* File: verif/awc_apb_host.sv */
// APB master model of the core side that feeds the execution unit
`timescale 1ns/10ps
`default_nettype none
module awc_apb_host (
   input wire logic pclk,
   input wire logic pready,
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [31:0] paddr,
   output logic [31:0] pwdata,
   output logic [3:0] pstrb
);
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 32'h0;
      pwdata = 32'h0;
      pstrb = 4'hf;
   end
   // =====
   // One transfer, held until pready is seen at a rising edge
   task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
                       input logic [3:0] s);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge pclk);
      penable <= 1'b1;
      // Read at the edge itself, so the value seen is the one the slave held before it
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      psel <= 1'b0;
      penable <= 1'b0;
      // Released lines flip so a stale value cannot pass for a fresh one
      paddr <= ~a;
      pwdata <= ~d;
      pstrb <= ~s;
   endtask
endmodule // awc_apb_host
`default_nettype wire

/* File: verif/tb.sv */
// Self-checking bench for the add-with-carry execution unit
`timescale 1ns/10ps
`default_nettype none
module tb;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel, penable, pwrite, pready, pslverr;
   logic [31:0] paddr, pwdata, prdata;
   logic [3:0] pstrb;
   logic [32:0] expq[$];
   logic [15:0] wr[16], mem[32], sr, lres;
   logic [23:0] li;
   logic [7:0] cnt;
   int mismatches = 0;
   int num_checks = 0;
   int cycles = 0;
   integer seed = 24218;
   always #2 pclk = ~pclk;
   awc_exec u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr));
   awc_apb_host u_host (.pclk(pclk), .pready(pready), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb));
   // =====
   // Checking and closing
   task automatic check(input string nm, input logic [32:0] seen, input logic [32:0] exp);
      num_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic test_done();
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   always @(negedge pclk) begin
      if (pready === 1'b1) begin
         check($sformatf("data at %h", paddr), {pslverr, prdata}, expq.pop_front());
      end
   end
   always @(posedge pclk) begin
      cycles <= cycles + 1;
      if (cycles == 40000) begin
         mismatches++;
         test_done();
      end
   end
   // =====
   // Bus access and reference model
   task automatic wr32(input logic [31:0] a, input logic [31:0] d, input logic err);
      expq.push_back({err, 32'h0});
      u_host.xfer(1'b1, a, d, 4'hf);
   endtask
   task automatic rd32(input logic [31:0] a, input logic [32:0] e);
      expq.push_back(e);
      u_host.xfer(1'b0, a, 32'h0, 4'h0);
   endtask
   task automatic put(input int k, input logic [15:0] v);
      if (k < 16) wr[k] = v;
      else mem[k - 16] = v;
      wr32(32'(64 + 4 * k), {~v, v}, 1'b0);
   endtask
   task automatic setsr(input logic [15:0] v);
      sr = v;
      wr32(32'h4, {~v, v}, 1'b0);
   endtask
   task automatic cmp_all(input string t);
      for (int k = 0; k < 48; k++) begin
         rd32(32'(64 + 4 * k), {17'h0, k < 16 ? wr[k] : mem[k - 16]});
      end
      rd32(32'h4, {17'h0, sr});
      $display("%s done", t);
   endtask
   function automatic logic [15:0] ea(input logic [2:0] m, input logic [3:0] n, input logic bo);
      logic [15:0] st;
      st = bo ? 16'h1 : 16'h2;
      if (m == 3'h4) wr[n] = wr[n] - st;
      if (m == 3'h5) wr[n] = wr[n] + st;
      ea = wr[n];
      if (m == 3'h2) wr[n] = wr[n] - st;
      if (m == 3'h3) wr[n] = wr[n] + st;
   endfunction
   task automatic run(input logic [23:0] i);
      logic [15:0] a, b, r, ad;
      logic [16:0] s;
      int p, q;
      wr32(32'h0, {8'h0, i}, 1'b0);
      li = i;
      p = i[14] ? 7 : 15;
      q = i[14] ? 4 : 8;
      a = wr[i[18:15]];
      if (i[6:5] == 2'h3) b = {11'h0, i[4:0]};
      else if (i[6:4] == 3'h0) b = wr[i[3:0]];
      else begin
         ad = ea(i[6:4], i[3:0], i[14]);
         b = mem[ad[5:1]] >> ((i[14] && ad[0]) ? 8 : 0);
      end
      if (i[14]) begin
         a = a & 16'hff;
         b = b & 16'hff;
      end
      s = a + b + sr[0];
      r = i[14] ? {8'h0, s[7:0]} : s[15:0];
      sr[8] = s[q] ^ a[q] ^ b[q];
      sr[3] = s[p];
      sr[2] = s[p] ^ a[p] ^ b[p] ^ s[p + 1];
      sr[1] = sr[1] & (r == 16'h0);
      sr[0] = s[p + 1];
      if (i[13:11] == 3'h0) begin
         if (i[14]) wr[i[10:7]][7:0] = r[7:0];
         else wr[i[10:7]] = r;
      end else begin
         ad = ea(i[13:11], i[10:7], i[14]);
         if (!i[14]) mem[ad[5:1]] = r;
         else if (ad[0]) mem[ad[5:1]][15:8] = r[7:0];
         else mem[ad[5:1]][7:0] = r[7:0];
      end
      cnt++;
      lres = r;
   endtask
   // =====
   // Main sequence
   initial begin
      logic [31:0] r;
      logic [3:0] b;
      wr = '{default: 16'h0};
      mem = '{default: 16'h0};
      sr = 16'h0;
      cnt = 8'h0;
      lres = 16'h0;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      rd32(32'h8, 33'h0);
      cmp_all("reset");
      put(1, 16'h00ff);
      for (int z = 0; z < 2; z++) begin
         setsr(z ? 16'h1 : 16'h3);
         run({5'h09, 4'h1, 1'b1, 3'h0, 4'h2, 2'h3, 5'h00});
         cmp_all("sticky zero");
      end
      put(0, 16'hcc80);
      put(7, 16'h12c0);
      put(16, 16'hb000);
      setsr(16'h0);
      run({5'h09, 4'h0, 1'b1, 3'h1, 4'h7, 2'h3, 5'h1f});
      put(3, 16'h6006);
      put(4, 16'h1000);
      put(47, 16'hddee);
      setsr(16'h1);
      run({5'h09, 4'h3, 1'b0, 3'h4, 4'h4, 2'h3, 5'h06});
      cmp_all("examples");
      rd32(32'h0, {9'h0, li});
      wr32(32'h0, {8'h0, 5'h09, 4'h1, 1'b0, 3'h6, 4'h2, 7'h0}, 1'b0);
      wr32(32'h0, {8'h0, 5'h08, 19'h0}, 1'b0);
      rd32(32'h0, {9'h0, 5'h08, 19'h0});
      rd32(32'h8, {1'b0, lres, 7'h0, 1'b1, cnt});
      wr32(32'h8, 32'h100, 1'b0);
      rd32(32'h8, {1'b0, lres, 7'h0, 1'b0, cnt});
      rd32(32'h0c, {1'b1, 32'h0});
      rd32(32'h100, {1'b1, 32'h0});
      rd32(32'h41, {1'b1, 32'h0});
      wr32(32'h3c, 32'hffff, 1'b1);
      // Only the upper status byte lane is enabled; the low byte must keep its value
      expq.push_back(33'h0);
      u_host.xfer(1'b1, 32'h4, 32'h0000_a5a5, 4'h2);
      sr[15:8] = 8'ha5;
      cmp_all("refusals");
      for (int n = 0; n < 40; n++) begin
         for (int k = 0; k < 48; k++) put(k, 16'($random(seed)));
         r = $random(seed);
         setsr(r[31:16]);
         b = r[3:0];
         run({5'h09, b, r[4], 3'(r[11:8] % 6), b + 4'ha, r[14:12], b + 4'h5});
         cmp_all("random");
      end
      test_done();
   end
endmodule // tb
bind awc_exec awc_assertions u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
   .prdata(prdata), .pready(pready), .pslverr(pslverr));
`default_nettype wire
